// ---- hdl/config_fuse_bank_params.svh ----
// Offsets, field positions, masks and reset values of the configuration bank.
// Assumes inclusion by bare name from design and bench files.
`ifndef CONFIG_FUSE_BANK_PARAMS_SVH
`define CONFIG_FUSE_BANK_PARAMS_SVH

// Register indices; byte address is four times the index
`define IDX_DEBUG_STACK_WDOG 22'h300000
`define IDX_CODE_PROTECT 22'h300001
`define IDX_OSC_SELECT 22'h300002
`define IDX_WDOG_POSTSCALE 22'h300003
`define IDX_EXTERNAL_BUS 22'h300004
`define IDX_PIN_ROUTING 22'h300005
`define IDX_IDENT_LOW 22'h3FFFFE
`define IDX_IDENT_HIGH 22'h3FFFFF

// Implemented bit masks, also the power-on values
`define MASK_DEBUG_STACK_WDOG 8'hE1
`define MASK_CODE_PROTECT 8'h04
`define MASK_OSC_SELECT 8'hC7
`define MASK_WDOG_POSTSCALE 8'h0F
`define MASK_EXTERNAL_BUS 8'hF8
`define MASK_PIN_ROUTING 8'h07

// Field positions
`define BIT_DEBUG_N 7
`define BIT_EXT_INSTR 6
`define BIT_STACK_FAULT 5
`define BIT_WDOG_FORCE 0
`define BIT_CODE_PROTECT_N 2
`define BIT_TWO_SPEED 7
`define BIT_CLOCK_MONITOR 6
`define BIT_DEFAULT_CLOCK 2
`define BIT_BUS_WAIT_N 7
`define BIT_BUS_WIDTH 6
`define BIT_BUS_MODE_LO 4
`define BIT_BUS_SHIFT 3
`define BIT_NET_LED 2
`define BIT_PWM_SECONDARY 1
`define BIT_PWM2_PRIMARY 0

// Timing: longest power-up load in cycles after reset release
`define LOAD_CYCLES_MAX 14

`endif

// ---- hdl/config_fuse_pkg.sv ----
// Types shared by the configuration bank.
// Assumes nothing beyond a SystemVerilog compiler.
package config_fuse_pkg;
  typedef enum logic [1:0] {
    OSC_CRYSTAL = 2'b00,
    OSC_CRYSTAL_PLL = 2'b01,
    OSC_EXT_CLOCKOUT = 2'b10,
    OSC_EXT_PLL_CLOCKOUT = 2'b11
  } osc_mode_t;
  typedef enum logic [1:0] {
    BUS_ADDR20 = 2'b00,
    BUS_ADDR16 = 2'b01,
    BUS_ADDR12 = 2'b10,
    BUS_OFF = 2'b11
  } bus_mode_t;
  typedef enum logic [1:0] {
    PWM2_ON_PORT_C = 2'b00,
    PWM2_ON_PORT_E = 2'b01,
    PWM2_ON_PORT_B = 2'b10
  } pwm2_loc_t;
  typedef enum logic [1:0] {
    LD_FETCH = 2'b00,
    LD_TAKE = 2'b01,
    LD_DONE = 2'b10
  } load_state_t;
endpackage : config_fuse_pkg

// ---- hdl/config_fuse_bank.sv ----
// Write-once configuration byte bank with two read-only identity bytes, APB slave.
// Assumes a program memory port answering one cycle after rom_addr, in the cycle rom_rd is high, on pclk.
// Decoded outputs are levels for the watchdog, clock, memory bus and pin-mux units.
//
// Contract
// - Each configuration bit accepts one programming write; later writes do nothing.
// - Unimplemented configuration bit positions read back as zero.
// - Debug bit one keeps debug pins general I/O; zero dedicates them.
// - Extended instruction bit one enables extension and indexed addressing.
// - Stack fault bit one makes stack overflow or underflow reset.
// - Watchdog bit one forces watchdog on; zero defers to software enable.
// - Code protect bit zero protects program memory; one leaves it open.
// - Second low byte bit 7 enables two-speed start-up.
// - Second low byte bit 6 enables fail-safe clock monitor.
// - Runtime select 00 uses internal RC unless default-clock bit is one.
// - Oscillator field picks external clock or crystal, with PLL and clock-out.
// - Watchdog postscale ratio is two to the power of the field.
// - Bus wait bit zero enables wait states with the control register count.
// - Data width bit one selects 16-bit bus, zero 8-bit.
// - Bus mode field selects off, 12, 16 or 20 address bits.
// - Address shift bit one offsets external addresses to start at zero.
// - LED mux bit routes network LEDs to pins while network enabled.
// - Secondary PWM mux bit picks port E when one, port H otherwise.
// - PWM2 primary on port C when one, else port E or B by mode.
// - Identity bytes are read-only: device code and revision code.
// - Cells go to one on power-on reset and survive other resets.
// - At power-up the bank loads itself from program memory.
// - A programmed bit refuses writes until power is cycled.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "config_fuse_bank_params.svh"

module config_fuse_bank #(
  parameter logic [10:0] DEVICE_CODE = 11'h123, // Arbitrary value
  parameter logic [4:0] REVISION_CODE = 5'h05, // Arbitrary value
  parameter int CFG_BYTES = 6
) (
  // Clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [23:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Program memory image port
  output logic rom_rd,
  output logic [2:0] rom_addr,
  input wire logic [7:0] rom_data,
  output logic load_done,
  // Live inputs from other units
  input wire logic watchdog_software_on,
  input wire logic [1:0] runtime_clock_select,
  input wire logic net_enable,
  // Decoded configuration
  output logic debug_pins_dedicated,
  output logic extended_instr_enable,
  output logic stack_fault_reset_enable,
  output logic watchdog_on,
  output logic program_protected,
  output logic two_speed_start_enable,
  output logic clock_monitor_enable,
  output logic system_clock_internal,
  output config_fuse_pkg::osc_mode_t oscillator_select,
  output logic [15:0] watchdog_ratio,
  output logic bus_wait_enable,
  output logic bus_data_width16,
  output config_fuse_pkg::bus_mode_t external_bus_mode,
  output logic bus_address_shift,
  output logic net_led_outputs_on_pins,
  output logic pwm_secondary_on_port_e,
  output config_fuse_pkg::pwm2_loc_t pwm2_primary_mux
);
  import config_fuse_pkg::*;

  // Cell count is fixed by the mask table and the index decode
  if (CFG_BYTES != 6) begin : g_bad_cfg_bytes
    $error("config_fuse_bank serves exactly six configuration bytes");
  end

  localparam logic [5:0][7:0] MASKS = {`MASK_PIN_ROUTING, `MASK_EXTERNAL_BUS,
    `MASK_WDOG_POSTSCALE, `MASK_OSC_SELECT, `MASK_CODE_PROTECT, `MASK_DEBUG_STACK_WDOG};
  localparam logic [2:0] LAST_BYTE = 3'h5;

  // Index 0..5 config, 6..7 identity; bit 3 marks a mapped word
  function automatic logic [3:0] decode(input logic [23:0] a);
    logic [21:0] w;
    w = a[23:2];
    decode = 4'h0;
    if (a[1:0] == 2'h0) begin
      if (w >= `IDX_DEBUG_STACK_WDOG && w <= `IDX_PIN_ROUTING) begin
        decode = {1'b1, w[2:0]};
      end else if (w == `IDX_IDENT_LOW) begin
        decode = 4'hE;
      end else if (w == `IDX_IDENT_HIGH) begin
        decode = 4'hF;
      end
    end
  endfunction : decode

  // Programming clears a bit; cleared bits never return to one
  function automatic logic [7:0] program_bits(input logic [7:0] cur, input logic [7:0] val,
      input logic [7:0] mask);
    program_bits = cur & (val | ~mask) & mask;
  endfunction : program_bits

  logic [5:0][7:0] cfg_q, cfg_d;
  load_state_t ld_q, ld_d;
  logic [2:0] rom_addr_q, rom_addr_d;
  logic rom_rd_q, rom_rd_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic watchdog_on_q, watchdog_on_d;
  logic sys_int_q, sys_int_d;
  logic [15:0] ratio_q, ratio_d;
  logic led_q, led_d;
  logic [3:0] dec;
  logic wr_take;
  logic dbg_q, dbg_d;
  logic prot_q, prot_d;
  logic bwait_q, bwait_d;
  logic done_q, done_d;
  pwm2_loc_t pwm2_q, pwm2_d;

  assign dec = decode(paddr);
  // Write lands only on the edge where pready is sampled high
  assign wr_take = psel && penable && pready_q && pwrite && dec[3] && (dec[2:0] <= LAST_BYTE);

  always_comb begin
    cfg_d = cfg_q;
    ld_d = ld_q;
    rom_addr_d = rom_addr_q;
    rom_rd_d = 1'b0;
    unique case (ld_q)
      LD_FETCH: begin
        rom_rd_d = 1'b1;
        ld_d = LD_TAKE;
      end
      LD_TAKE: begin
        cfg_d[rom_addr_q] = program_bits(cfg_q[rom_addr_q], rom_data, MASKS[rom_addr_q]);
        if (rom_addr_q == LAST_BYTE) begin
          ld_d = LD_DONE;
        end else begin
          rom_addr_d = rom_addr_q + 3'h1;
          ld_d = LD_FETCH;
        end
      end
      LD_DONE: begin
        if (wr_take) begin
          cfg_d[dec[2:0]] = program_bits(cfg_q[dec[2:0]], pwdata[7:0],
            MASKS[dec[2:0]]);
        end
      end
      default: begin
        ld_d = LD_DONE;
      end
    endcase
  end

  // Only the power-on reset touches the cells; no other reset reaches them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= MASKS;
      ld_q <= LD_FETCH;
      rom_addr_q <= 3'h0;
      rom_rd_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      ld_q <= ld_d;
      rom_addr_q <= rom_addr_d;
      rom_rd_q <= rom_rd_d;
    end
  end

  // Bus answer; stalls during load so no write races the image
  always_comb begin
    pready_d = psel && penable && !pready_q && (ld_q == LD_DONE);
    pslverr_d = pready_d && !dec[3];
    prdata_d = 32'h0;
    if (pready_d && !pwrite) begin
      if (dec == 4'hE) begin
        prdata_d = {24'h0, DEVICE_CODE[2:0], REVISION_CODE};
      end else if (dec == 4'hF) begin
        prdata_d = {24'h0, DEVICE_CODE[10:3]};
      end else if (dec[3]) begin
        prdata_d = {24'h0, cfg_q[dec[2:0]] & MASKS[dec[2:0]]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // Decodes that mix in live inputs are registered so outputs stay flop-driven
  always_comb begin
    watchdog_on_d = cfg_q[0][`BIT_WDOG_FORCE] | watchdog_software_on;
    sys_int_d = (runtime_clock_select == 2'b00) && !cfg_q[2][`BIT_DEFAULT_CLOCK];
    ratio_d = 16'h1 << cfg_q[3][3:0];
    led_d = cfg_q[5][`BIT_NET_LED] & net_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watchdog_on_q <= 1'b1;
      sys_int_q <= 1'b0;
      ratio_q <= 16'h8000;
      led_q <= 1'b0;
    end else begin
      watchdog_on_q <= watchdog_on_d;
      sys_int_q <= sys_int_d;
      ratio_q <= ratio_d;
      led_q <= led_d;
    end
  end

  // Inverted and muxed decodes get own flops fed from next cell values, so no lag
  always_comb begin
    dbg_d = !cfg_d[0][`BIT_DEBUG_N];
    prot_d = !cfg_d[1][`BIT_CODE_PROTECT_N];
    bwait_d = !cfg_d[4][`BIT_BUS_WAIT_N];
    done_d = (ld_d == LD_DONE);
    pwm2_d = PWM2_ON_PORT_B;
    if (cfg_d[5][`BIT_PWM2_PRIMARY]) begin
      pwm2_d = PWM2_ON_PORT_C;
    end else if (cfg_d[4][`BIT_BUS_MODE_LO +: 2] == 2'b11) begin
      pwm2_d = PWM2_ON_PORT_E;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_q <= 1'b0;
      prot_q <= 1'b0;
      bwait_q <= 1'b0;
      done_q <= 1'b0;
      pwm2_q <= PWM2_ON_PORT_C;
    end else begin
      dbg_q <= dbg_d;
      prot_q <= prot_d;
      bwait_q <= bwait_d;
      done_q <= done_d;
      pwm2_q <= pwm2_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rom_rd = rom_rd_q;
  assign rom_addr = rom_addr_q;
  assign load_done = done_q;
  assign debug_pins_dedicated = dbg_q;
  assign extended_instr_enable = cfg_q[0][`BIT_EXT_INSTR];
  assign stack_fault_reset_enable = cfg_q[0][`BIT_STACK_FAULT];
  assign watchdog_on = watchdog_on_q;
  assign program_protected = prot_q;
  assign two_speed_start_enable = cfg_q[2][`BIT_TWO_SPEED];
  assign clock_monitor_enable = cfg_q[2][`BIT_CLOCK_MONITOR];
  assign system_clock_internal = sys_int_q;
  assign oscillator_select = osc_mode_t'(cfg_q[2][1:0]);
  assign watchdog_ratio = ratio_q;
  assign bus_wait_enable = bwait_q;
  assign bus_data_width16 = cfg_q[4][`BIT_BUS_WIDTH];
  assign external_bus_mode = bus_mode_t'(cfg_q[4][`BIT_BUS_MODE_LO +: 2]);
  assign bus_address_shift = cfg_q[4][`BIT_BUS_SHIFT];
  assign net_led_outputs_on_pins = led_q;
  assign pwm_secondary_on_port_e = cfg_q[5][`BIT_PWM_SECONDARY];
  assign pwm2_primary_mux = pwm2_q;

  // Checks
  localparam int LOAD_MAX = `LOAD_CYCLES_MAX;
  logic [4:0] since_rst_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_rst_q <= 5'h0;
    end else if (since_rst_q != 5'h1F) begin
      since_rst_q <= since_rst_q + 5'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Live-input decodes lag one cycle; their checks skip the edge after reset release
  a_cells_never_rise: assert property (((cfg_q & ~$past(cfg_q)) == 48'h0))
    else $error("configuration bit returned to one");
  a_cells_quiet: assert property ((ld_q == LD_DONE && !wr_take) |=> $stable(cfg_q))
    else $error("cells changed without a write");
  a_unimpl_zero: assert property ((cfg_q & ~MASKS) == 48'h0)
    else $error("unimplemented configuration bit set");
  a_write_locked: assert property ((wr_take && !cfg_q[dec[2:0]][0])
      |=> !cfg_q[$past(dec[2:0])][0])
    else $error("programmed bit changed by later write");
  a_por_masks: assert property ($past(!presetn) |-> cfg_q == MASKS)
    else $error("cells not at one after power-on reset");
  a_rom_order: assert property ((rom_rd && rom_addr != LAST_BYTE)
      |=> ##1 (rom_rd && rom_addr == $past(rom_addr, 2) + 3'h1))
    else $error("image fetch out of order");
  a_fetch_single: assert property (rom_rd |=> !rom_rd)
    else $error("image fetch held two cycles");
  a_load_bound: assert property ((since_rst_q >= 5'(LOAD_MAX)) |-> load_done)
    else $error("power-up load too slow");
  a_load_state_legal: assert property (ld_q != 2'b11)
    else $error("load state illegal");
  a_debug_pins: assert property (debug_pins_dedicated != cfg_q[0][`BIT_DEBUG_N])
    else $error("debug pin ownership wrong");
  a_protect_level: assert property (program_protected != cfg_q[1][`BIT_CODE_PROTECT_N])
    else $error("code protection level wrong");
  a_bus_wait: assert property (bus_wait_enable != cfg_q[4][`BIT_BUS_WAIT_N])
    else $error("bus wait enable wrong");
  a_watchdog_follow: assert property ($past(presetn) |->
      watchdog_on == $past(cfg_q[0][`BIT_WDOG_FORCE] | watchdog_software_on))
    else $error("watchdog enable wrong");
  a_clock_internal: assert property ($past(presetn) |->
      sys_int_q == $past((runtime_clock_select == 2'b00) && !cfg_q[2][`BIT_DEFAULT_CLOCK]))
    else $error("system clock choice wrong");
  a_ratio_pow2: assert property ($past(presetn) |->
      ratio_q == (16'h1 << $past(cfg_q[3][3:0])))
    else $error("postscale ratio wrong");
  a_led_mux: assert property ($past(presetn) |->
      led_q == $past(cfg_q[5][`BIT_NET_LED] & net_enable))
    else $error("led routing wrong");
  a_osc_decode: assert property ((cfg_q[2][1:0] == 2'b11)
      |-> oscillator_select == OSC_EXT_PLL_CLOCKOUT)
    else $error("oscillator mode wrong");
  a_bus_off: assert property ((cfg_q[4][`BIT_BUS_MODE_LO +: 2] == 2'b11)
      |-> external_bus_mode == BUS_OFF)
    else $error("bus mode wrong");
  a_pwm2_portc: assert property (cfg_q[5][0] |-> pwm2_primary_mux == PWM2_ON_PORT_C)
    else $error("pwm2 routing wrong");
  a_pwm2_portb: assert property ((!cfg_q[5][0] && cfg_q[4][`BIT_BUS_MODE_LO +: 2] != 2'b11)
      |-> pwm2_primary_mux == PWM2_ON_PORT_B)
    else $error("pwm2 extended routing wrong");
  a_ident_read: assert property ((psel && penable && !pready_q && load_done
      && !pwrite && dec == 4'hE) |=> prdata == {24'h0, DEVICE_CODE[2:0], REVISION_CODE})
    else $error("identity low byte wrong");
  a_ident_high: assert property ((psel && penable && !pready_q && load_done
      && !pwrite && dec == 4'hF) |=> prdata == {24'h0, DEVICE_CODE[10:3]})
    else $error("identity high byte wrong");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  a_stall_in_load: assert property ((ld_q != LD_DONE) |=> !pready)
    else $error("bus answered during image load");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_slverr_decode: assert property (pready |-> (pslverr == !dec[3]))
    else $error("pslverr does not match address decode");
  a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside transfer");

  c_cfg_write: cover property (wr_take);
  c_ident_read: cover property (pready && !pwrite && dec[3:1] == 3'b111);
  c_unmapped: cover property (pready && pslverr);
  c_load_done: cover property ($rose(load_done));
endmodule : config_fuse_bank
`default_nettype wire

// ---- verif/test_config_fuse_bank.sv ----
// Self-checking bench for the write-once configuration bank, driven over APB.
// Assumes the bank header on the include path; the bench also plays program memory.
`timescale 1ns/1ps
`default_nettype none
`include "config_fuse_bank_params.svh"

module test_config_fuse_bank;
  import config_fuse_pkg::*;
  localparam logic [10:0] DEV = 11'h2A5; // Arbitrary value
  localparam logic [4:0] REV = 5'h0B; // Arbitrary value
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [23:0] paddr = 24'h000000;
  logic [31:0] pwdata = 32'h00000000;
  logic [7:0] rom_data = 8'h00;
  logic sw_on = 1'b0;
  logic [1:0] rt_sel = 2'b00;
  logic net_en = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, rom_rd, load_done, dbg, xi, stk, wd_on, prot, two, mon, sys_int;
  logic [2:0] rom_addr;
  logic [15:0] ratio;
  logic bwait, bw16, shft, led, sec;
  osc_mode_t osc;
  bus_mode_t bmode;
  pwm2_loc_t p2;
  int num_errors = 0;
  int compares = 0;
  // Image keeps bit 3 of the first high byte low and upper nibbles high
  logic [7:0] img [8] = '{8'hFF, 8'hF7, 8'hFF, 8'hFB, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

  config_fuse_bank #(.DEVICE_CODE(DEV), .REVISION_CODE(REV), .CFG_BYTES(6))
    config_fuse_bank_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rom_rd(rom_rd), .rom_addr(rom_addr), .rom_data(rom_data), .load_done(load_done),
    .watchdog_software_on(sw_on), .runtime_clock_select(rt_sel), .net_enable(net_en),
    .debug_pins_dedicated(dbg), .extended_instr_enable(xi), .stack_fault_reset_enable(stk),
    .watchdog_on(wd_on), .program_protected(prot), .two_speed_start_enable(two),
    .clock_monitor_enable(mon), .system_clock_internal(sys_int), .oscillator_select(osc),
    .watchdog_ratio(ratio), .bus_wait_enable(bwait), .bus_data_width16(bw16),
    .external_bus_mode(bmode), .bus_address_shift(shft), .net_led_outputs_on_pins(led),
    .pwm_secondary_on_port_e(sec), .pwm2_primary_mux(p2));

  always #20 pclk = ~pclk;
  // Memory answers one cycle after the address, in the same cycle as the fetch pulse
  always @(posedge pclk) rom_data <= img[rom_addr];

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [23:0] a, input logic [7:0] d,
      output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    chk("access cycles", 32'(n), 32'h2);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [21:0] i, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, {i, 2'b00}, d, r, e);
    repeat (2) @(posedge pclk);
    #1;
  endtask : wr

  task automatic rdc(input logic [21:0] i, input logic [7:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, {i, 2'b00}, 8'h00, r, e);
    chk("read", r, {24'h000000, x});
  endtask : rdc

  task automatic por;
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    chk("ratio in reset", 32'(ratio), 32'h8000);
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (13) @(posedge pclk);
    #1;
    chk("load_done", 32'(load_done), 32'h1);
    chk("rom addr", 32'(rom_addr), 32'h5);
    chk("rom rd", 32'(rom_rd), 32'h0);
  endtask : por

  task automatic t_load;
    rdc(`IDX_DEBUG_STACK_WDOG, 8'hE1);
    rdc(`IDX_CODE_PROTECT, 8'h04);
    rdc(`IDX_OSC_SELECT, 8'hC7);
    rdc(`IDX_WDOG_POSTSCALE, 8'h0B);
    rdc(`IDX_EXTERNAL_BUS, 8'hF8);
    rdc(`IDX_PIN_ROUTING, 8'h07);
    rdc(`IDX_IDENT_LOW, {DEV[2:0], REV});
    rdc(`IDX_IDENT_HIGH, DEV[10:3]);
    chk("ratio", 32'(ratio), 32'h0800);
    chk("dbg xi stk", {dbg, xi, stk}, 3'b011);
    chk("prot", 32'(prot), 32'h0);
    chk("two mon", {two, mon}, 2'b11);
    chk("osc", 32'(osc), 32'(OSC_EXT_PLL_CLOCKOUT));
    chk("bus bits", {bwait, bw16, bmode, shft}, {4'b0111, 1'b1});
    chk("sec", 32'(sec), 32'h1);
    chk("p2", 32'(p2), 32'(PWM2_ON_PORT_C));
  endtask : t_load

  task automatic t_once;
    chk("wd forced", 32'(wd_on), 32'h1);
    wr(`IDX_DEBUG_STACK_WDOG, 8'h1E);
    rdc(`IDX_DEBUG_STACK_WDOG, 8'h00);
    chk("dbg xi stk", {dbg, xi, stk}, 3'b100);
    wr(`IDX_DEBUG_STACK_WDOG, 8'hFF);
    rdc(`IDX_DEBUG_STACK_WDOG, 8'h00);
    chk("wd soft off", 32'(wd_on), 32'h0);
    @(posedge pclk) sw_on <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk("wd soft on", 32'(wd_on), 32'h1);
    wr(`IDX_CODE_PROTECT, 8'hFB);
    chk("prot", 32'(prot), 32'h1);
  endtask : t_once

  task automatic t_clock;
    chk("sys int", 32'(sys_int), 32'h0);
    wr(`IDX_OSC_SELECT, 8'h3E);
    chk("two mon", {two, mon}, 2'b00);
    chk("osc", 32'(osc), 32'(OSC_EXT_CLOCKOUT));
    wr(`IDX_OSC_SELECT, 8'hF8);
    chk("osc", 32'(osc), 32'(OSC_CRYSTAL));
    chk("sys int", 32'(sys_int), 32'h1);
    @(posedge pclk) rt_sel <= 2'b01;
    repeat (2) @(posedge pclk);
    #1;
    chk("sys int", 32'(sys_int), 32'h0);
    wr(`IDX_WDOG_POSTSCALE, 8'h03);
    chk("ratio", 32'(ratio), 32'h0008);
    wr(`IDX_WDOG_POSTSCALE, 8'h00);
    chk("ratio", 32'(ratio), 32'h0001);
  endtask : t_clock

  task automatic t_bus;
    @(posedge pclk) net_en <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    chk("led", 32'(led), 32'h1);
    wr(`IDX_PIN_ROUTING, 8'hFC);
    chk("sec", 32'(sec), 32'h0);
    chk("p2", 32'(p2), 32'(PWM2_ON_PORT_E));
    wr(`IDX_EXTERNAL_BUS, 8'h1F);
    chk("p2", 32'(p2), 32'(PWM2_ON_PORT_B));
    chk("bus bits", {bwait, bw16, bmode, shft}, {4'b1001, 1'b1});
    wr(`IDX_EXTERNAL_BUS, 8'h07);
    chk("bus mode", {bmode, shft}, 3'b000);
    wr(`IDX_PIN_ROUTING, 8'h00);
    chk("led", 32'(led), 32'h0);
  endtask : t_bus

  task automatic t_bad;
    logic [31:0] r;
    logic e;
    apb(1'b0, 24'h000010, 8'h00, r, e);
    chk("unmapped data", r, 32'h0);
    chk("unmapped err", 32'(e), 32'h1);
    apb(1'b0, {`IDX_PIN_ROUTING, 2'b01}, 8'h00, r, e);
    chk("misaligned data", r, 32'h0);
    chk("misaligned err", 32'(e), 32'h1);
    wr(`IDX_IDENT_LOW, 8'h00);
    rdc(`IDX_IDENT_LOW, {DEV[2:0], REV});
  endtask : t_bad

  task automatic t_repower;
    por();
    rdc(`IDX_DEBUG_STACK_WDOG, 8'hE1);
    wr(`IDX_OSC_SELECT, 8'hFD);
    chk("osc", 32'(osc), 32'(OSC_CRYSTAL_PLL));
  endtask : t_repower

  task automatic end_of_test;
    $display("Compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    por();
    t_load();
    t_once();
    t_clock();
    t_bus();
    t_bad();
    t_repower();
    end_of_test();
  end

  // Whole run is about two hundred cycles; this span is far beyond it
  initial begin
    #200000;
    num_errors++;
    end_of_test();
  end
endmodule : test_config_fuse_bank
`default_nettype wire
